/* rtl/arb_pkg.sv */
/*
  Constants for the result, limit and alert register bank: register
  addresses, field positions, source tags, power-up values and timing.
  Assumes one core clock at the rate given here.
*/
package arb_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND        = 8'h00;
  localparam logic [7:0] ADDR_VOLTAGE_RESULT = 8'h01;
  localparam logic [7:0] ADDR_TEMP_RESULT    = 8'h02;
  localparam logic [7:0] ADDR_TEMP_AVERAGE   = 8'h03;
  localparam logic [7:0] ADDR_LIMIT_BASE     = 8'h04;
  localparam logic [7:0] ADDR_INPUT0_HYST    = 8'h06;
  localparam logic [7:0] ADDR_ALERT_STATUS_A = 8'h1f;
  localparam logic [7:0] ADDR_ALERT_STATUS_B = 8'h20;
  localparam int         LIMIT_STRIDE        = 3;
  localparam int         UPPER_OFFSET        = 0;
  localparam int         LOWER_OFFSET        = 1;
  localparam int         HYST_OFFSET         = 2;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int CMD_AUTOCYCLE_BIT   = 0;
  localparam int CMD_SW_RESET_BIT    = 1;
  localparam int CMD_CLEAR_ALERT_BIT = 2;
  localparam int CMD_POLARITY_BIT    = 3;
  localparam int CMD_EXT_REF_BIT     = 4;
  localparam int CMD_NOISE_DELAY_BIT = 5;
  localparam int CMD_TEMP_ENABLE_BIT = 7;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] CMD_KEEP_MASK = 16'hffbd;

  // ----------------------------------------------------------------
  // Source tags and limit sets
  // ----------------------------------------------------------------
  localparam int         NUM_VOLTAGE      = 8;
  localparam int         NUM_SETS         = 9;
  localparam int         TEMP_SET         = 8;
  localparam int         NUM_ALERT_SRC    = 10;
  localparam logic [3:0] TAG_TEMPERATURE  = 4'h8;
  localparam logic [3:0] TAG_TEMP_AVERAGE = 4'h9;

  // ----------------------------------------------------------------
  // Power-up values
  // ----------------------------------------------------------------
  localparam logic [11:0] VOLT_UPPER_RESET = 12'hfff;
  localparam logic [11:0] VOLT_LOWER_RESET = 12'h000;
  localparam logic [11:0] TEMP_UPPER_RESET = 12'h7ff;
  localparam logic [11:0] TEMP_LOWER_RESET = 12'h800;
  localparam logic [11:0] HYST_RESET       = 12'h000;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ          = 40;
  localparam int TEMP_INTERVAL_US   = 5000;
  localparam int TEMP_PERIOD_CYCLES = TEMP_INTERVAL_US * CLOCK_MHZ;
  localparam int AVG_SHIFT          = 3;

endpackage : arb_pkg

/* rtl/arb_bank.sv */
/*
  Result, limit and alert register bank of an eight-input monitoring
  converter with a temperature source. Registers are reached from the
  serial link engine on its own clock; accesses cross to the core clock
  by a toggle handshake. Assumes the conversion engine runs on the core
  clock and delivers results at least two core cycles apart.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Result word is 4-bit source tag in bits 15:12 over 12-bit value.
// - Tags 0-7 voltage inputs, 8 temperature, 9 averaged temperature.
// - Temperature result is 12-bit two's complement in a read-only register.
// - Temperature LSB weighs a quarter degree, MSB minus 512 degrees.
// - New temperature conversion about every 5 ms while enabled.
// - Averaged temperature register refreshes after each temperature conversion.
// - Nine limit sets of upper, lower and hysteresis, 12 used bits.
// - Limit and hysteresis registers read and write; bits 15:12 read zero.
// - Power-up: voltage upper limits full scale, lower limits zero.
// - Power-up temperature limits 0x7ff and 0x800; compare as two's complement.
// - Alert raised when result strictly above upper limit.
// - Upper alert released once result is N codes below upper limit.
// - Alert raised when result strictly below lower limit.
// - Lower alert released once result is N codes above lower limit.
// - N comes from the source's hysteresis register; averaged temperature uses the temperature one.
// - Writing one to command bit 2 deasserts the alert output.
// - Hysteresis registers power up as zero.
// - Input zero hysteresis register sits at address 0x06.
// - Command bit 3 set gives active-low alert, clear gives active-high.
// - Each violation sets a status bit per source and side.
module arb_bank
  import arb_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYCLES
) (
  input  wire logic        clock_in,            // Core clock, 40 MHz
  input  wire logic        resetn_in,           // Asynchronous reset, active low
  input  wire logic        link_clock_in,       // Link engine clock
  input  wire logic [7:0]  reg_addr_in,         // Register pointer
  input  wire logic [15:0] reg_wdata_in,        // Write word, upper byte first
  input  wire logic        reg_write_in,        // Write request pulse
  input  wire logic        reg_read_in,         // Read request pulse
  output logic      [15:0] reg_rdata_out,       // Read word
  output logic             reg_done_out,        // Access finished pulse
  output logic             reg_busy_out,        // Access in flight
  input  wire logic        conv_valid_in,       // Conversion finished pulse
  input  wire logic [3:0]  conv_source_in,      // Source of the result
  input  wire logic [11:0] conv_data_in,        // Conversion value
  output logic             temp_request_out,    // Start temperature conversion
  output logic      [7:0]  channel_select_out,  // Inputs chosen for conversion
  output logic             autocycle_out,       // Continuous conversion mode
  output logic             ext_ref_out,         // External reference chosen
  output logic             noise_delay_out,     // Quiet-bus conversion mode
  output logic             alert_out            // Limit alert pin
);

  // ----------------------------------------------------------------
  // Link side request capture
  // ----------------------------------------------------------------
  logic        lk_req_tgl;
  logic        lk_we;
  logic [7:0]  lk_addr;
  logic [15:0] lk_wdata;
  logic        lk_ack_s1;
  logic        lk_ack_s2;
  logic        lk_ack_s3;
  logic        cr_ack_tgl;
  logic [15:0] cr_rd_hold;

  wire lk_start = !reg_busy_out && (reg_write_in || reg_read_in);
  wire lk_ack   = lk_ack_s2 ^ lk_ack_s3;

  always_ff @(posedge link_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_req_tgl <= 1'b0;
      lk_we      <= 1'b0;
      lk_addr    <= 8'h00;
      lk_wdata   <= 16'h0000;
    end else if (lk_start) begin
      lk_req_tgl <= ~lk_req_tgl;
      lk_we      <= reg_write_in;
      lk_addr    <= reg_addr_in;
      lk_wdata   <= reg_wdata_in;
    end
  end

  always_ff @(posedge link_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_ack_s1     <= 1'b0;
      lk_ack_s2     <= 1'b0;
      lk_ack_s3     <= 1'b0;
      reg_busy_out  <= 1'b0;
      reg_done_out  <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else begin
      lk_ack_s1    <= cr_ack_tgl;
      lk_ack_s2    <= lk_ack_s1;
      lk_ack_s3    <= lk_ack_s2;
      reg_done_out <= lk_ack;
      if (lk_start) begin
        reg_busy_out <= 1'b1;
      end else if (lk_ack) begin
        reg_busy_out <= 1'b0;
      end
      if (lk_ack) begin
        reg_rdata_out <= cr_rd_hold;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side request detection and decode
  // ----------------------------------------------------------------
  logic cr_req_s1;
  logic cr_req_s2;
  logic cr_req_s3;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cr_req_s1 <= 1'b0;
      cr_req_s2 <= 1'b0;
      cr_req_s3 <= 1'b0;
    end else begin
      cr_req_s1 <= lk_req_tgl;
      cr_req_s2 <= cr_req_s1;
      cr_req_s3 <= cr_req_s2;
    end
  end

  wire cr_req      = cr_req_s2 ^ cr_req_s3;
  wire cr_wr       = cr_req && lk_we;
  wire cmd_wr      = cr_wr && (lk_addr == ADDR_COMMAND);
  wire sw_reset    = cmd_wr && lk_wdata[CMD_SW_RESET_BIT];
  wire clear_alert = cmd_wr && lk_wdata[CMD_CLEAR_ALERT_BIT];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] command;
  logic [15:0] voltage_result;
  logic [15:0] temperature_result;
  logic [15:0] temperature_average_result;
  logic        avg_valid;
  logic [11:0] upper_limit [NUM_SETS];
  logic [11:0] lower_limit [NUM_SETS];
  logic [11:0] hysteresis  [NUM_SETS];
  logic [NUM_SETS-1:0] wr_upper;
  logic [NUM_SETS-1:0] wr_lower;
  logic [NUM_SETS-1:0] wr_hyst;
  logic [NUM_SETS-1:0] sel_upper;
  logic [NUM_SETS-1:0] sel_lower;
  logic [NUM_SETS-1:0] sel_hyst;

  wire temp_en   = command[CMD_TEMP_ENABLE_BIT];
  wire conv_volt = conv_valid_in && (conv_source_in < 4'(NUM_VOLTAGE));
  wire conv_temp = conv_valid_in && (conv_source_in == TAG_TEMPERATURE);

  // Input zero hysteresis lands on 0x06 since base + 2 = 0x06
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SETS; gs++) begin : g_set
      assign sel_upper[gs] = lk_addr == 8'(ADDR_LIMIT_BASE + LIMIT_STRIDE*gs + UPPER_OFFSET);
      assign sel_lower[gs] = lk_addr == 8'(ADDR_LIMIT_BASE + LIMIT_STRIDE*gs + LOWER_OFFSET);
      assign sel_hyst[gs]  = lk_addr == 8'(ADDR_LIMIT_BASE + LIMIT_STRIDE*gs + HYST_OFFSET);
      assign wr_upper[gs]  = cr_wr && sel_upper[gs];
      assign wr_lower[gs]  = cr_wr && sel_lower[gs];
      assign wr_hyst[gs]   = cr_wr && sel_hyst[gs];
    end
  endgenerate

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      command <= CMD_RESET;
    end else if (sw_reset) begin
      command <= CMD_RESET;
    end else if (cmd_wr) begin
      command <= lk_wdata & CMD_KEEP_MASK;
    end
  end

  // Limit sets keep only 12 bits; upper nibble always reads zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_SETS; i++) begin
        upper_limit[i] <= (i == TEMP_SET) ? TEMP_UPPER_RESET : VOLT_UPPER_RESET;
        lower_limit[i] <= (i == TEMP_SET) ? TEMP_LOWER_RESET : VOLT_LOWER_RESET;
        hysteresis[i]  <= HYST_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_SETS; i++) begin
        if (sw_reset) begin
          upper_limit[i] <= (i == TEMP_SET) ? TEMP_UPPER_RESET : VOLT_UPPER_RESET;
          lower_limit[i] <= (i == TEMP_SET) ? TEMP_LOWER_RESET : VOLT_LOWER_RESET;
          hysteresis[i]  <= HYST_RESET;
        end else begin
          if (wr_upper[i]) upper_limit[i] <= lk_wdata[11:0];
          if (wr_lower[i]) lower_limit[i] <= lk_wdata[11:0];
          if (wr_hyst[i])  hysteresis[i]  <= lk_wdata[11:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Results and temperature averaging
  // ----------------------------------------------------------------
  logic signed [13:0] avg_old;
  logic signed [13:0] avg_new;
  logic signed [13:0] avg_diff;
  logic signed [13:0] avg_sum;
  logic        [11:0] next_avg;

  assign avg_old  = {{2{temperature_average_result[11]}}, temperature_average_result[11:0]};
  assign avg_new  = {{2{conv_data_in[11]}}, conv_data_in};
  assign avg_diff = avg_new - avg_old;
  assign avg_sum  = avg_old + (avg_diff >>> AVG_SHIFT);
  assign next_avg = avg_valid ? avg_sum[11:0] : conv_data_in;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      voltage_result             <= RESULT_RESET;
      temperature_result         <= RESULT_RESET;
      temperature_average_result <= RESULT_RESET;
      avg_valid                  <= 1'b0;
    end else if (sw_reset) begin
      voltage_result             <= RESULT_RESET;
      temperature_result         <= RESULT_RESET;
      temperature_average_result <= RESULT_RESET;
      avg_valid                  <= 1'b0;
    end else begin
      if (conv_volt) begin
        voltage_result <= {conv_source_in, conv_data_in};
      end
      // Quarter-degree two's complement code kept as delivered
      if (conv_temp) begin
        temperature_result         <= {TAG_TEMPERATURE, conv_data_in};
        temperature_average_result <= {TAG_TEMP_AVERAGE, next_avg};
        avg_valid                  <= 1'b1;
      end else if (!temp_en) begin
        avg_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature conversion interval
  // ----------------------------------------------------------------
  logic [31:0] temp_timer;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      temp_timer       <= 32'h0000_0000;
      temp_request_out <= 1'b0;
    end else if (!temp_en || sw_reset) begin
      temp_timer       <= 32'h0000_0000;
      temp_request_out <= 1'b0;
    end else if (temp_timer == 32'(TEMP_PERIOD - 1)) begin
      temp_timer       <= 32'h0000_0000;
      temp_request_out <= 1'b1;
    end else begin
      temp_timer       <= temp_timer + 32'h0000_0001;
      temp_request_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison per alert source
  // ----------------------------------------------------------------
  logic [NUM_ALERT_SRC-1:0] hi_active;
  logic [NUM_ALERT_SRC-1:0] lo_active;
  logic [NUM_ALERT_SRC-1:0] hi_status;
  logic [NUM_ALERT_SRC-1:0] lo_status;
  logic [NUM_ALERT_SRC-1:0] next_hi_active;
  logic [NUM_ALERT_SRC-1:0] next_lo_active;
  logic [NUM_ALERT_SRC-1:0] next_hi_status;
  logic [NUM_ALERT_SRC-1:0] next_lo_status;

  genvar ga;
  generate
    for (ga = 0; ga < NUM_ALERT_SRC; ga++) begin : g_alert
      localparam int  SET    = (ga >= TEMP_SET) ? TEMP_SET : ga;
      localparam bit  SIGNED = (ga >= TEMP_SET);
      wire [11:0] value  = (ga == NUM_SETS) ? next_avg : conv_data_in;
      wire        hit    = (ga == NUM_SETS) ? conv_temp
                         : conv_valid_in && (conv_source_in == 4'(ga));
      wire        ext_v  = SIGNED && value[11];
      wire        ext_u  = SIGNED && upper_limit[SET][11];
      wire        ext_l  = SIGNED && lower_limit[SET][11];
      wire signed [13:0] val = {{2{ext_v}}, value};
      wire signed [13:0] upr = {{2{ext_u}}, upper_limit[SET]};
      wire signed [13:0] lwr = {{2{ext_l}}, lower_limit[SET]};
      wire signed [13:0] hys = {2'b00, hysteresis[SET]};
      wire        over   = hit && (val > upr);
      wire        under  = hit && (val < lwr);
      wire        hi_rel = hit && (val <= upr - hys);
      wire        lo_rel = hit && (val >= lwr + hys);
      // A violation in the clearing cycle is kept
      assign next_hi_active[ga] = over || (hi_active[ga] && !hi_rel && !clear_alert);
      assign next_lo_active[ga] = under || (lo_active[ga] && !lo_rel && !clear_alert);
      assign next_hi_status[ga] = over || (hi_status[ga] && !clear_alert);
      assign next_lo_status[ga] = under || (lo_status[ga] && !clear_alert);
    end
  endgenerate

  wire alert_any = |next_hi_active || |next_lo_active;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_active <= '0;
      lo_active <= '0;
      hi_status <= '0;
      lo_status <= '0;
      alert_out <= 1'b0;
    end else if (sw_reset) begin
      hi_active <= '0;
      lo_active <= '0;
      hi_status <= '0;
      lo_status <= '0;
      alert_out <= 1'b0;
    end else begin
      hi_active <= next_hi_active;
      lo_active <= next_lo_active;
      hi_status <= next_hi_status;
      lo_status <= next_lo_status;
      alert_out <= alert_any ^ command[CMD_POLARITY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] status_a;
  logic [15:0] status_b;
  logic [15:0] limit_rd;
  logic [15:0] rd_mux;

  genvar gb;
  generate
    for (gb = 0; gb < NUM_VOLTAGE; gb++) begin : g_stat
      assign status_a[2*gb+1] = hi_status[gb];
      assign status_a[2*gb]   = lo_status[gb];
    end
  endgenerate
  assign status_b = {12'h000, hi_status[NUM_SETS], lo_status[NUM_SETS],
                     hi_status[TEMP_SET], lo_status[TEMP_SET]};

  always_comb begin
    limit_rd = 16'h0000;
    for (int i = 0; i < NUM_SETS; i++) begin
      if (sel_upper[i]) limit_rd = {4'h0, upper_limit[i]};
      if (sel_lower[i]) limit_rd = {4'h0, lower_limit[i]};
      if (sel_hyst[i])  limit_rd = {4'h0, hysteresis[i]};
    end
  end

  assign rd_mux = (lk_addr == ADDR_COMMAND)        ? command
                : (lk_addr == ADDR_VOLTAGE_RESULT) ? voltage_result
                : (lk_addr == ADDR_TEMP_RESULT)    ? temperature_result
                : (lk_addr == ADDR_TEMP_AVERAGE)   ? temperature_average_result
                : (lk_addr == ADDR_ALERT_STATUS_A) ? status_a
                : (lk_addr == ADDR_ALERT_STATUS_B) ? status_b
                : limit_rd;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cr_rd_hold <= 16'h0000;
      cr_ack_tgl <= 1'b0;
    end else if (cr_req) begin
      cr_rd_hold <= rd_mux;
      cr_ack_tgl <= ~cr_ack_tgl;
    end
  end

  assign channel_select_out = command[15:8];
  assign autocycle_out      = command[CMD_AUTOCYCLE_BIT];
  assign ext_ref_out        = command[CMD_EXT_REF_BIT];
  assign noise_delay_out    = command[CMD_NOISE_DELAY_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire signed [13:0] in0_release = {2'b00, upper_limit[0]} - {2'b00, hysteresis[0]};

  property p_voltage_format;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    conv_volt |=> voltage_result == {$past(conv_source_in), $past(conv_data_in)};
  endproperty
  a_voltage_format: assert property (p_voltage_format)
    else $error("voltage result word not tagged with its source");

  property p_temp_format;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    conv_temp |=> temperature_result == {4'h8, $past(conv_data_in)};
  endproperty
  a_temp_format: assert property (p_temp_format)
    else $error("temperature result word wrong");

  property p_first_average;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    conv_temp && !avg_valid |=> temperature_average_result == {4'h9, $past(conv_data_in)};
  endproperty
  a_first_average: assert property (p_first_average)
    else $error("first average not equal to first temperature result");

  property p_upper_raise;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    conv_valid_in && conv_source_in == 4'h0 && conv_data_in > upper_limit[0]
      |=> hi_status[0] && hi_active[0] ##1 alert_out != command[3];
  endproperty
  a_upper_raise: assert property (p_upper_raise)
    else $error("upper violation on input zero not flagged");

  property p_lower_raise;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    conv_temp && $signed(conv_data_in) < $signed(lower_limit[8])
      |=> lo_status[8] && lo_active[8];
  endproperty
  a_lower_raise: assert property (p_lower_raise)
    else $error("lower temperature violation not flagged");

  property p_upper_release;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    hi_active[0] && conv_valid_in && conv_source_in == 4'h0
      && $signed({2'b00, conv_data_in}) <= in0_release |=> !hi_active[0];
  endproperty
  a_upper_release: assert property (p_upper_release)
    else $error("upper alert on input zero not released");

  property p_clear_alert;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    clear_alert && !conv_valid_in |=> hi_status == '0 && lo_status == '0
      ##1 alert_out == command[3];
  endproperty
  a_clear_alert: assert property (p_clear_alert)
    else $error("clear alert did not release the alert");

  property p_polarity;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    ##1 alert_out == ($past(command[3]) ? !$past(alert_any) : $past(alert_any));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("alert pin polarity wrong");

  property p_temp_interval;
    @(posedge clock_in) disable iff (!resetn_in || sw_reset)
    temp_request_out && temp_en |=> !temp_request_out && temp_timer == 32'h0000_0001;
  endproperty
  a_temp_interval: assert property (p_temp_interval)
    else $error("temperature request not a single pulse restarting the interval");

endmodule : arb_bank

`default_nettype wire

/* tb/arb_host.sv */
/*
  Host model for the bank's register port: one word access per call.
  Assumes a free-running link clock and the done pulse of the bank.
*/
`timescale 1ns/1ps
`default_nettype none
module arb_host (
  input  wire logic        lclk_in,  // Link clock
  input  wire logic        done_in,  // Access finished
  input  wire logic [15:0] rdata_in, // Read word
  output logic      [7:0]  addr_out, // Register pointer
  output logic      [15:0] data_out, // Write word
  output logic             wr_out,   // Write pulse
  output logic             rd_out    // Read pulse
);
  initial {addr_out, data_out, wr_out, rd_out} = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge lclk_in) #1;
    addr_out = a;
    data_out = d;
    wr_out = w;
    rd_out = !w;
    @(posedge lclk_in) #1;
    {wr_out, rd_out} = 2'b00;
    {addr_out, data_out} = ~{a, d};
    while (done_in !== 1'b1 && n < 64) begin
      @(posedge lclk_in) #1;
      n++;
    end
    q = rdata_in;
  endtask
endmodule // arb_host
`default_nettype wire

/* tb/arb_bank_bench.sv */
/*
  Bench for the result, limit and alert bank.
  Assumes the package, the bank and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module arb_bank_bench;
  import arb_pkg::*;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cv = 1'b0;
  logic [3:0]  src = 4'h0;
  logic [11:0] val = 12'h000;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, q;
  logic        wr, rd, done, busy, treq, alert;
  logic [7:0]  chsel;
  logic        acyc, extref, noise;
  int          num_errors = 0;
  int          checks_done = 0;
  always #12.5 clk = ~clk;
  initial #7 forever #16 lclk = ~lclk;
  arb_bank #(.TEMP_PERIOD(20)) u_dut (.clock_in(clk), .resetn_in(rstn), .link_clock_in(lclk),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .reg_done_out(done), .reg_busy_out(busy), .conv_valid_in(cv),
    .conv_source_in(src), .conv_data_in(val), .temp_request_out(treq),
    .channel_select_out(chsel), .autocycle_out(acyc), .ext_ref_out(extref),
    .noise_delay_out(noise),
    .alert_out(alert));
  arb_host u_host (.lclk_in(lclk), .done_in(done), .rdata_in(rdata), .addr_out(addr),
    .data_out(wdata), .wr_out(wr), .rd_out(rd));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    u_host.acc(1'b0, a, 16'h0000, q);
    chk("done busy", {14'h0, done, busy}, 16'h0002);
    chk("register", q, exp);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    u_host.acc(1'b1, a, d, q);
    chk("done busy", {14'h0, done, busy}, 16'h0002);
  endtask
  task automatic ala(input logic exp);
    repeat (3) @(posedge clk);
    #1;
    chk("alert", {15'h0, alert}, {15'h0, exp});
  endtask
  task automatic conv(input logic [3:0] s, input logic [11:0] d);
    @(posedge clk) #1;
    cv = 1'b1;
    src = s;
    val = d;
    @(posedge clk) #1;
    cv = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge lclk);
    for (int i = 0; i < NUM_SETS; i++) begin
      rdc(8'(ADDR_LIMIT_BASE + 3 * i), (i == TEMP_SET) ? 16'h07ff : 16'h0fff);
      rdc(8'(ADDR_LIMIT_BASE + 3 * i + 1), (i == TEMP_SET) ? 16'h0800 : 16'h0000);
      rdc(8'(ADDR_INPUT0_HYST + 3 * i), 16'h0000);
    end
    wrr(ADDR_INPUT0_HYST, 16'h0008);
    rdc(ADDR_INPUT0_HYST, 16'h0008);
    wrr(8'h04, 16'h0800);
    wrr(8'h05, 16'h0100);
    rdc(8'h05, 16'h0100);
    conv(4'h0, 12'h801);
    ala(1'b1);
    rdc(ADDR_VOLTAGE_RESULT, 16'h0801);
    rdc(ADDR_ALERT_STATUS_A, 16'h0002);
    conv(4'h0, 12'h7f9);
    ala(1'b1);
    conv(4'h0, 12'h7f8);
    ala(1'b0);
    conv(4'h0, 12'h0ff);
    ala(1'b1);
    conv(4'h0, 12'h107);
    ala(1'b1);
    wrr(ADDR_COMMAND, 16'h0004);
    ala(1'b0);
    wrr(ADDR_COMMAND, 16'h0008);
    ala(1'b1);
    conv(4'h0, 12'h0ff);
    ala(1'b0);
    wrr(ADDR_COMMAND, 16'h0084);
    for (int k = 0; k < 100 && treq !== 1'b1; k++) @(posedge clk) #1;
    chk("temp request", {15'h0, treq}, 16'h0001);
    conv(TAG_TEMPERATURE, 12'hffc);
    ala(1'b0);
    rdc(ADDR_TEMP_RESULT, 16'h8ffc);
    rdc(ADDR_TEMP_AVERAGE, 16'h9ffc);
    conv(TAG_TEMPERATURE, 12'h004);
    rdc(ADDR_TEMP_AVERAGE, 16'h9ffd);
    wrr(8'h1d, 16'h0000);
    conv(TAG_TEMPERATURE, 12'hffe);
    ala(1'b1);
    rdc(ADDR_ALERT_STATUS_B, 16'h0005);
    wrr(ADDR_COMMAND, 16'ha5b5);
    ala(1'b0);
    rdc(ADDR_COMMAND, 16'ha5b5);
    chk("command pins", {chsel, 5'h00, acyc, extref, noise}, 16'ha507);
    wrr(ADDR_COMMAND, 16'h0002);
    rdc(ADDR_COMMAND, 16'h0000);
    rdc(ADDR_INPUT0_HYST, 16'h0000);
    rdc(8'h05, 16'h0000);
    rdc(8'h1d, 16'h0800);
    rdc(ADDR_ALERT_STATUS_B, 16'h0000);
    end_sim();
  end
endmodule // arb_bank_bench
`default_nettype wire
